// ===== vrid_consts.vh
// Constants for the vendor register bank with ID-resistor converter
//
// Behaviour
// - Vendor registers occupy addresses 30h to 3Fh
// - Boost bits 6:5 select transmit amplitude step
// - Boost register bits 0-4,7 read zero
// - Headset mode only when nibble equals 1010
// - Headset register upper nibble reads zero
// - Conversion register read 36-38h, write/set/clear
// - Bits 2:0 hold measured ID resistance code
// - Result code mirrored in carkit status register
// - Done flag bit 3 set after 282us
// - Conversion register read clears done; carkit read keeps
// - Start bit 4 launches conversion, self-clears
// - Enabled done flag raises alt_int
// - Effective enable ORs both enable bits
// - Latch bit 3 on enabled done rise, clear-on-read
`ifndef VRID_CONSTS_VH
`define VRID_CONSTS_VH
`define VRID_ADDR_LO        6'h30
`define VRID_ADDR_HI        6'h3F
`define VRID_ADDR_BOOST     6'h31
`define VRID_ADDR_HEADSET   6'h33
`define VRID_ADDR_CONV_WR   6'h36
`define VRID_ADDR_CONV_SET  6'h37
`define VRID_ADDR_CONV_CLR  6'h38
`define VRID_ADDR_CK_STAT   6'h20
`define VRID_ADDR_CK_LATCH  6'h21
`define VRID_HEADSET_KEY    4'hA
`define VRID_CONV_TIME_NS   282000
`define VRID_CLK_PERIOD_NS  10
`define VRID_CONV_WR_MASK   8'h70
`define VRID_BIT_DONE       3
`define VRID_BIT_GO         4
`define VRID_BIT_IEN        6
`define VRID_CODE_ERROR     3'h7
`endif

// ===== vrid_edge_sync.v
// Two-flop synchroniser with edge detection for the link clock
`timescale 1ns/1ps
`default_nettype none
module vrid_edge_sync
(
   input  wire i_ref_clk,
   input  wire i_rst,
   input  wire i_async,
   output reg  o_level,
   output reg  o_rise
);
   reg meta;
   reg prev;
   always @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         meta    <= 1'b0;
         o_level <= 1'b0;
         prev    <= 1'b0;
         o_rise  <= 1'b0;
      end
      else
      begin
         meta    <= i_async;
         o_level <= meta;
         prev    <= o_level;
         o_rise  <= o_level & ~prev;
      end
   end
endmodule // vrid_edge_sync
`default_nettype wire

// ===== vrid_regs.v
// Vendor register bank: boost, headset mode, ID-resistor converter
`timescale 1ns/1ps
`default_nettype none
`include "vrid_consts.vh"
module vrid_regs
#(
   parameter CONV_CYCLES = (`VRID_CONV_TIME_NS + `VRID_CLK_PERIOD_NS - 1)
                           / `VRID_CLK_PERIOD_NS
)
(
   input  wire       i_ref_clk,
   input  wire       i_rst,
   input  wire       i_link_clk,
   input  wire       i_reg_wr,
   input  wire       i_reg_rd,
   input  wire [5:0] i_reg_addr,
   input  wire [7:0] i_reg_wdata,
   input  wire       i_carkit_irq_enable,
   input  wire [2:0] i_id_resistor_meas,
   output reg  [7:0] o_reg_rdata,
   output reg        o_reg_rvalid,
   output reg  [1:0] o_tx_boost,
   output reg        o_headset_mode,
   output reg        o_id_conversion_active,
   output reg  [2:0] o_carkit_id_resistor_code,
   output reg        o_carkit_id_conversion_done,
   output reg        o_id_conversion_latch,
   output reg        o_alt_int
);
   // ****************************************************
   // Request sampling on the link clock
   // ****************************************************
   // Request strobes are on link timing; ref clock finds its edges
   wire       link_level;
   wire       link_rise;
   reg  [5:0] addr_s1;
   reg  [5:0] addr_s2;
   reg  [7:0] wdata_s1;
   reg  [7:0] wdata_s2;
   reg  [1:0] wr_s;
   reg  [1:0] rd_s;
   reg  [2:0] meas_s1;
   reg  [2:0] meas_s2;
   reg  [1:0] ck_en_s;

   vrid_edge_sync u_link_sync
   (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   (i_link_clk),
      .o_level   (link_level),
      .o_rise    (link_rise)
   );

   always @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         addr_s1  <= 6'h00;
         addr_s2  <= 6'h00;
         wdata_s1 <= 8'h00;
         wdata_s2 <= 8'h00;
         wr_s     <= 2'h0;
         rd_s     <= 2'h0;
         meas_s1  <= 3'h0;
         meas_s2  <= 3'h0;
         ck_en_s  <= 2'h0;
      end
      else
      begin
         addr_s1  <= i_reg_addr;
         addr_s2  <= addr_s1;
         wdata_s1 <= i_reg_wdata;
         wdata_s2 <= wdata_s1;
         wr_s     <= {wr_s[0], i_reg_wr};
         rd_s     <= {rd_s[0], i_reg_rd};
         meas_s1  <= i_id_resistor_meas;
         meas_s2  <= meas_s1;
         ck_en_s  <= {ck_en_s[0], i_carkit_irq_enable};
      end
   end

   // At most one write and one read per rising link edge
   wire wr_take = link_rise & wr_s[1];
   wire rd_take = link_rise & rd_s[1];

   // ****************************************************
   // Register state
   // ****************************************************
   reg  [1:0]  boost;
   reg  [3:0]  headset;
   reg  [2:0]  id_resistor_code;
   reg         id_conversion_done;
   reg         id_conversion_go;
   reg         rsvd5;
   reg         id_conversion_irq_enable;
   reg  [31:0] conv_cnt;
   reg         done_prev;

   wire [7:0] conv_val = {1'b0, id_conversion_irq_enable, rsvd5,
                          id_conversion_go, id_conversion_done,
                          id_resistor_code};
   wire       irq_en_eff = id_conversion_irq_enable | ck_en_s[1];
   wire       conv_end = id_conversion_go && (conv_cnt == 32'h0);
   wire       conv_rd = rd_take && (addr_s2 >= `VRID_ADDR_CONV_WR)
                        && (addr_s2 <= `VRID_ADDR_CONV_CLR);
   wire       latch_rd = rd_take && (addr_s2 == `VRID_ADDR_CK_LATCH);
   wire       latch_set = irq_en_eff & id_conversion_done & ~done_prev;

   // Only bits 6:4 are link-writable; code and done belong to hardware
   function [7:0] i_reg_wdata_mask;
      input [7:0] d;
      begin
         i_reg_wdata_mask = d & `VRID_CONV_WR_MASK;
      end
   endfunction

   reg  [7:0] next_conv;
   always @*
   begin
      next_conv = conv_val;
      if (wr_take)
      begin
         case (addr_s2)
            `VRID_ADDR_CONV_WR:
               next_conv = (conv_val & ~`VRID_CONV_WR_MASK)
                         | (i_reg_wdata_mask(wdata_s2));
            `VRID_ADDR_CONV_SET:
               next_conv = conv_val | i_reg_wdata_mask(wdata_s2);
            `VRID_ADDR_CONV_CLR:
               next_conv = conv_val & ~i_reg_wdata_mask(wdata_s2);
            default:
               next_conv = conv_val;
         endcase
      end
   end

   always @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         boost                    <= 2'h0;
         headset                  <= 4'h0;
         id_resistor_code         <= 3'h0;
         id_conversion_done       <= 1'b0;
         id_conversion_go         <= 1'b0;
         rsvd5                    <= 1'b0;
         id_conversion_irq_enable <= 1'b0;
         conv_cnt                 <= 32'h0;
         done_prev                <= 1'b0;
         o_id_conversion_latch    <= 1'b0;
      end
      else
      begin
         done_prev <= id_conversion_done;
         if (wr_take && addr_s2 == `VRID_ADDR_BOOST)
            boost <= wdata_s2[6:5];
         if (wr_take && addr_s2 == `VRID_ADDR_HEADSET)
            headset <= wdata_s2[3:0];
         // Bit 5 kept as written; link must hold it at zero
         rsvd5                    <= next_conv[5];
         id_conversion_irq_enable <= next_conv[`VRID_BIT_IEN];
         if (conv_end)
         begin
            id_conversion_go   <= 1'b0;
            id_conversion_done <= 1'b1;
            id_resistor_code   <= meas_s2;
         end
         else
         begin
            id_conversion_go <= next_conv[`VRID_BIT_GO];
            if (next_conv[`VRID_BIT_GO] && !id_conversion_go)
               conv_cnt <= CONV_CYCLES - 1;
            else if (id_conversion_go)
               conv_cnt <= conv_cnt - 32'h1;
            if (conv_rd)
               id_conversion_done <= 1'b0;
         end
         // Set wins over a clearing read in the same cycle
         if (latch_set)
            o_id_conversion_latch <= 1'b1;
         else if (latch_rd)
            o_id_conversion_latch <= 1'b0;
      end
   end

   // ****************************************************
   // Read path and outputs
   // ****************************************************
   reg [7:0] next_rdata;
   always @*
   begin
      case (addr_s2)
         `VRID_ADDR_BOOST:     next_rdata = {1'b0, boost, 5'h00};
         `VRID_ADDR_HEADSET:   next_rdata = {4'h0, headset};
         `VRID_ADDR_CONV_WR,
         `VRID_ADDR_CONV_SET,
         `VRID_ADDR_CONV_CLR:  next_rdata = conv_val;
         `VRID_ADDR_CK_STAT:   next_rdata = {1'b0, id_conversion_done,
                                             id_resistor_code, 3'h0};
         `VRID_ADDR_CK_LATCH:  next_rdata = {4'h0, o_id_conversion_latch,
                                             3'h0};
         default:              next_rdata = 8'h00;
      endcase
   end

   always @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_reg_rdata                 <= 8'h00;
         o_reg_rvalid                <= 1'b0;
         o_tx_boost                  <= 2'h0;
         o_headset_mode              <= 1'b0;
         o_id_conversion_active      <= 1'b0;
         o_carkit_id_resistor_code   <= 3'h0;
         o_carkit_id_conversion_done <= 1'b0;
         o_alt_int                   <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= rd_take;
         if (rd_take)
            o_reg_rdata <= next_rdata;
         o_tx_boost                  <= boost;
         o_headset_mode              <= (headset == `VRID_HEADSET_KEY);
         o_id_conversion_active      <= id_conversion_go;
         o_carkit_id_resistor_code   <= id_resistor_code;
         o_carkit_id_conversion_done <= id_conversion_done;
         o_alt_int <= irq_en_eff & id_conversion_done;
      end
   end
endmodule // vrid_regs
`default_nettype wire

// ===== vrid_regs_chk.sv
// Port assertions for the vendor register bank
`timescale 1ns/1ps
`default_nettype none
module vrid_regs_chk
(
   input wire logic       i_ref_clk,
   input wire logic       i_rst,
   input wire logic       i_reg_wr,
   input wire logic [5:0] i_reg_addr,
   input wire logic       i_carkit_irq_enable,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       o_reg_rvalid,
   input wire logic [1:0] o_tx_boost,
   input wire logic       o_headset_mode,
   input wire logic       o_id_conversion_active,
   input wire logic       o_carkit_id_conversion_done,
   input wire logic       o_alt_int
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   // ****
   // Checks
   // ****
   rv_pulse_a: assert property (o_reg_rvalid |=> !o_reg_rvalid)
      else $error("read valid too long");
   boost_rd_a: assert property (o_reg_rvalid && i_reg_addr == 6'h31
      |-> o_reg_rdata == {1'b0, o_tx_boost, 5'h00}) else $error("boost read");
   head_rd_a: assert property (o_reg_rvalid && i_reg_addr == 6'h33
      |-> o_reg_rdata[7:4] == 4'h0
      && (o_reg_rdata[3:0] == 4'hA) == o_headset_mode) else $error("headset");
   ctl_hold_a: assert property ((!i_reg_wr)[*8]
      |-> $stable(o_tx_boost) && $stable(o_headset_mode)) else $error("ctl");
   done_src_a: assert property ($rose(o_carkit_id_conversion_done)
      |-> $past(o_id_conversion_active) || $past(o_id_conversion_active, 2))
      else $error("done without start");
   conv_len_a: assert property ($rose(o_id_conversion_active)
      |=> o_id_conversion_active[*8]) else $error("conversion too short");
   alt_en_a: assert property ((o_carkit_id_conversion_done
      && i_carkit_irq_enable)[*3]
      // A clearing read may drop done; alt drops with it in the same cycle
      |=> o_alt_int || !o_carkit_id_conversion_done) else $error("alt missing");
   alt_src_a: assert property (o_alt_int |-> o_carkit_id_conversion_done
      || $past(o_carkit_id_conversion_done)) else $error("alt without done");
endmodule // vrid_regs_chk
`default_nettype wire

// ===== vrid_link.sv
// Link controller model: link clock and register requests
`timescale 1ns/1ps
`default_nettype none
module vrid_link
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rvalid,
   input  wire logic [7:0] i_rdata,
   output var  logic       o_link_clk,
   output var  logic       o_reg_wr,
   output var  logic       o_reg_rd,
   output var  logic [5:0] o_reg_addr,
   output var  logic [7:0] o_reg_wdata
);
   initial
   begin
      {o_link_clk, o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = 17'h00000;
      forever #62.5 o_link_clk = ~o_link_clk;
   end
   // ****
   // One access per link cycle
   // ****
   task automatic xfer(input logic w, input logic [5:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      q = 8'hXX;
      @(negedge o_link_clk);
      o_reg_addr = a;
      o_reg_wdata = (a inside {6'h36, 6'h37, 6'h38}) ? d & 8'hDF : d;
      {o_reg_wr, o_reg_rd} = {w, !w};
      @(posedge o_link_clk);
      repeat (5)
      begin
         @(negedge i_ref_clk);
         if (!w && i_rvalid)
            q = i_rdata;
      end
      @(negedge o_link_clk);
      // Released lines show the inverse, never a stale value
      {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = {2'b00, ~a, ~d};
   endtask
endmodule // vrid_link
`default_nettype wire

// ===== test_vendor_regs_id_resistor_ctrl.sv
// Self-checking bench for the vendor register bank
`timescale 1ns/1ps
`default_nettype none
module test_vendor_regs_id_resistor_ctrl;
   // Short conversion keeps the run brief
   localparam int CONV = 20;
   logic       clk, rst, lclk, wr, rd, cken, rv, head, act, done, latch, alt;
   logic [5:0] addr;
   logic [7:0] wd, rdat, q;
   logic [2:0] meas, code;
   logic [1:0] boost;
   int         n_mismatch, total_checks, cyc;
   wire logic [7:0] st = {alt, latch, act, done, 1'b0, code};
   logic [24:0] tab [9] = '{
      {6'h31, 8'hFF, 8'h60, 3'h6}, {6'h31, 8'h20, 8'h20, 3'h2},
      {6'h31, 8'h40, 8'h40, 3'h4}, {6'h31, 8'h00, 8'h00, 3'h0},
      {6'h33, 8'h0A, 8'h0A, 3'h1}, {6'h33, 8'hFF, 8'h0F, 3'h0},
      {6'h33, 8'h5A, 8'h0A, 3'h1}, {6'h3F, 8'hFF, 8'h00, 3'h1},
      {6'h36, 8'h8F, 8'h00, 3'h1}};
   vrid_regs #(.CONV_CYCLES(CONV)) u_dut
   (
      .i_ref_clk(clk), .i_rst(rst), .i_link_clk(lclk), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
      .i_carkit_irq_enable(cken), .i_id_resistor_meas(meas),
      .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_tx_boost(boost),
      .o_headset_mode(head), .o_id_conversion_active(act),
      .o_carkit_id_resistor_code(code), .o_carkit_id_conversion_done(done),
      .o_id_conversion_latch(latch), .o_alt_int(alt)
   );
   vrid_link u_link
   (
      .i_ref_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_link_clk(lclk),
      .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wd)
   );
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
      if (++cyc == 4000)
      begin
         n_mismatch++;
         conclude();
      end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      u_link.xfer(1'b0, a, 8'h00, q);
      check(q, e);
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ****
   // Sequence
   // ****
   initial
   begin
      {rst, cken, meas} = 5'h15;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      check(st, 8'h00);
      rd_chk(6'h36, 8'h00);
      foreach (tab[i])
      begin
         u_link.xfer(1'b1, tab[i][24:19], tab[i][18:11], q);
         rd_chk(tab[i][24:19], tab[i][10:3]);
         check({5'h00, boost, head}, {5'h00, tab[i][2:0]});
      end
      u_link.xfer(1'b1, 6'h37, 8'h10, q);
      check(st, 8'h20);
      repeat (CONV + 4) @(negedge clk);
      check(st, 8'h15);
      rd_chk(6'h20, 8'h68);
      rd_chk(6'h36, 8'h0D);
      rd_chk(6'h38, 8'h05);
      @(posedge clk) #1 {cken, meas} = 4'hF;
      u_link.xfer(1'b1, 6'h36, 8'h10, q);
      repeat (CONV + 4) @(negedge clk);
      check(st, 8'hD7);
      rd_chk(6'h21, 8'h08);
      check(st, 8'h97);
      @(posedge clk) #1 {cken, meas} = 4'h2;
      rd_chk(6'h37, 8'h0F);
      check(st, 8'h07);
      u_link.xfer(1'b1, 6'h36, 8'h50, q);
      repeat (CONV + 4) @(negedge clk);
      check(st, 8'hD2);
      u_link.xfer(1'b1, 6'h38, 8'h40, q);
      check(st, 8'h52);
      rd_chk(6'h36, 8'h0A);
      // Mid-run reset with latch and headset mode set; the last read has cleared done
      @(posedge clk) #1 rst = 1'b1;
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      check(st, 8'h00);
      check({5'h00, boost, head}, 8'h00);
      // Let the link synchroniser settle before the next request
      repeat (4) @(negedge clk);
      rd_chk(6'h33, 8'h00);
      rd_chk(6'h36, 8'h00);
      conclude();
   end
endmodule // test_vendor_regs_id_resistor_ctrl
bind vrid_regs vrid_regs_chk u_chk
(
   .i_ref_clk                   (i_ref_clk),
   .i_rst                       (i_rst),
   .i_reg_wr                    (i_reg_wr),
   .i_reg_addr                  (i_reg_addr),
   .i_carkit_irq_enable         (i_carkit_irq_enable),
   .o_reg_rdata                 (o_reg_rdata),
   .o_reg_rvalid                (o_reg_rvalid),
   .o_tx_boost                  (o_tx_boost),
   .o_headset_mode              (o_headset_mode),
   .o_id_conversion_active      (o_id_conversion_active),
   .o_carkit_id_conversion_done (o_carkit_id_conversion_done),
   .o_alt_int                   (o_alt_int)
);
`default_nettype wire
